// file: core/fpcls_params.svh
// What this block does
// [RL1] Accept seven operand formats.
// [RL2] Packed decimal: three words, 3/17 digits.
// [RL3] Low packed words map to bits 63..0.
// [RL4] Packed decimal has exponent and mantissa signs.
// [RL5] Fourth exponent digit catches conversion overflow.
// [RL6] Don't-care fields written zero, ignored read.
// [RL7] Exponent is unsigned biased; unbias gives signed.
// [RL8] Normalized mantissa lies in 1.0 to 2.0.
// [RL9] Extended explicit integer bit; others implied one.
// [RL10] Classify binary operands into five types; the code adds a sixth, FPCLS_UNNORM, for extended operands.
// [RL11] Single/double normals avoid min and max exponent.
// [RL12] Packed decimal never denormalized.
// [RL13] Single/double zero exponent means denormalized.
// [RL14] Extended zero exponent with integer one: normalized.
// [RL15] Normalized extended has integer bit set.
// [RL16] Denormalized extended has integer bit clear.
// [RL17] Flag underflow when exponent at or below minimum.
// [RL18] Gradual underflow shifts right to minimum exponent.
// [RL19] Extended nonzero exponent, integer zero: unnormalized.
// [RL20] Denormal or unnormal operand raises unimplemented trap.
// [RL21] Recognise signed zeros by mantissa sign.
// [RL22] Max exponent, zero fraction: signed infinity.
// [RL23] NaN top fraction bit set: nonsignaling.
// [RL24] Zero: minimum exponent, fraction bits all zero.
`ifndef FPCLS_PARAMS_SVH
`define FPCLS_PARAMS_SVH
`define FPCLS_SGL_EXP_MAX 15'h00ff
`define FPCLS_DBL_EXP_MAX 15'h07ff
`define FPCLS_EXT_EXP_MAX 15'h7fff
`define FPCLS_SGL_BIAS 16'h007f
`define FPCLS_DBL_BIAS 16'h03ff
`define FPCLS_EXT_BIAS 16'h3fff
`define FPCLS_SGL_FRAC_W 23
`define FPCLS_DBL_FRAC_W 52
`define FPCLS_PKD_SM_BIT 95
`define FPCLS_PKD_SE_BIT 94
`define FPCLS_PKD_EXP_HI 91
`define FPCLS_PKD_EXP_LO 80
`define FPCLS_PKD_OVF_HI 79
`define FPCLS_PKD_OVF_LO 76
`define FPCLS_PKD_DIG16_HI 67
`define FPCLS_PKD_DIG16_LO 64
`define FPCLS_MIN_EXP 16'h0000
`define FPCLS_SHIFT_MAX 7'h41
`endif

// file: core/fpcls_pkg.sv
`default_nettype none
package fpcls_pkg;
  typedef enum logic [2:0] {
    FPCLS_BYTE, FPCLS_WORD, FPCLS_LONG, FPCLS_PACKED, FPCLS_SINGLE, FPCLS_DOUBLE, FPCLS_EXTENDED
  } fpcls_fmt_e;
  typedef enum logic [2:0] {
    FPCLS_NORM, FPCLS_DENORM, FPCLS_ZERO, FPCLS_INF, FPCLS_NAN, FPCLS_UNNORM, FPCLS_INTEGER
  } fpcls_type_e;
  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] mant;
    fpcls_fmt_e fmt;
  } fpcls_unpk_s;
endpackage
`default_nettype wire

// file: core/fpcls_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpcls_if;
  import fpcls_pkg::*;
  logic vld;
  fpcls_unpk_s opd;
  modport src (output vld, output opd);
  modport dst (input vld, input opd);
endinterface
`default_nettype wire

// file: core/fpcls_unpack.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpcls_params.svh"
module fpcls_unpack
  import fpcls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_vld,
  input wire fpcls_fmt_e i_fmt,
  input wire logic [95:0] i_data,
  fpcls_if.src o_bus
);
  // ==========================================
  // Field unpacking, one registered stage.
  fpcls_unpk_s nxt_opd;
  always_comb begin
    nxt_opd = '0;
    nxt_opd.fmt = i_fmt; // [RL1]
    unique case (i_fmt)
      FPCLS_SINGLE: begin
        nxt_opd.sign = i_data[31];
        nxt_opd.exp = {7'h00, i_data[30:23]}; // [RL7]
        nxt_opd.mant = {(i_data[30:23] != 8'h00), i_data[22:0], 40'h0}; // [RL9] [RL13]
      end
      FPCLS_DOUBLE: begin
        nxt_opd.sign = i_data[63];
        nxt_opd.exp = {4'h0, i_data[62:52]};
        nxt_opd.mant = {(i_data[62:52] != 11'h000), i_data[51:0], 11'h0}; // [RL9] [RL13]
      end
      FPCLS_EXTENDED: begin
        nxt_opd.sign = i_data[95];
        nxt_opd.exp = i_data[94:80];
        nxt_opd.mant = i_data[63:0]; // [RL9]
      end
      FPCLS_PACKED: begin
        // Only decoded fields are kept, so don't-care nibbles never leak through.
        nxt_opd.sign = i_data[`FPCLS_PKD_SM_BIT]; // [RL4] [RL6]
        nxt_opd.exp = {i_data[`FPCLS_PKD_SE_BIT], 2'h0, i_data[`FPCLS_PKD_EXP_HI:`FPCLS_PKD_EXP_LO]}; // [RL2] [RL4]
        nxt_opd.mant = i_data[63:0]; // [RL3]
      end
      FPCLS_BYTE: nxt_opd.mant = {{56{i_data[7]}}, i_data[7:0]};
      FPCLS_WORD: nxt_opd.mant = {{48{i_data[15]}}, i_data[15:0]};
      FPCLS_LONG: nxt_opd.mant = {{32{i_data[31]}}, i_data[31:0]};
      default: nxt_opd.mant = '0;
    endcase
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus.vld <= 1'b0;
      o_bus.opd <= '0;
    end else begin
      o_bus.vld <= i_vld;
      o_bus.opd <= nxt_opd;
    end
  end
endmodule
`default_nettype wire

// file: core/fpcls_denorm.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpcls_params.svh"
module fpcls_denorm
  import fpcls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic signed [15:0] i_exp,
  input wire logic [63:0] i_mant,
  output logic o_busy,
  output logic o_done,
  output logic o_uflow,
  output logic [63:0] o_mant,
  output logic signed [15:0] o_exp
);
  // ==========================================
  // Gradual underflow, one bit per cycle; slow but tiny.
  logic busy_ff, done_ff, uflow_ff;
  logic [63:0] mant_ff;
  logic signed [15:0] exp_ff;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      uflow_ff <= 1'b0;
      mant_ff <= '0;
      exp_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (i_start && !busy_ff) begin
        uflow_ff <= (i_exp <= $signed(`FPCLS_MIN_EXP)); // [RL17]
        mant_ff <= i_mant;
        exp_ff <= i_exp;
        busy_ff <= (i_exp < $signed(`FPCLS_MIN_EXP));
        done_ff <= !(i_exp < $signed(`FPCLS_MIN_EXP));
      end else if (busy_ff) begin
        if (exp_ff < $signed(`FPCLS_MIN_EXP) && mant_ff != '0) begin
          mant_ff <= mant_ff >> 1; // [RL18]
          exp_ff <= exp_ff + 16'sd1;
        end else begin
          if (mant_ff == '0) begin
            exp_ff <= $signed(`FPCLS_MIN_EXP); // [RL18]
          end
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_uflow = uflow_ff;
  assign o_mant = mant_ff;
  assign o_exp = exp_ff;
endmodule
`default_nettype wire

// file: core/fpcls_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpcls_params.svh"
module fpcls_top
  import fpcls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_vld,
  input wire fpcls_fmt_e i_fmt,
  input wire logic [95:0] i_data,
  input wire logic i_uf_start,
  input wire logic signed [15:0] i_uf_exp,
  input wire logic [63:0] i_uf_mant,
  output logic o_vld,
  output fpcls_type_e o_type,
  output logic o_sign,
  output logic signed [15:0] o_exp,
  output logic [63:0] o_mant,
  output logic o_snan,
  output logic o_unimp_trap,
  output logic [3:0] o_overflow_exponent_digit,
  output logic o_uf_busy,
  output logic o_uf_done,
  output logic o_uf_flag,
  output logic [63:0] o_uf_mant,
  output logic signed [15:0] o_uf_exp
);
  fpcls_if u_bus ();
  fpcls_unpack u_unpack (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_vld(i_vld),
    .i_fmt(i_fmt),
    .i_data(i_data),
    .o_bus(u_bus.src)
  );
  fpcls_denorm u_denorm (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(i_uf_start),
    .i_exp(i_uf_exp),
    .i_mant(i_uf_mant),
    .o_busy(o_uf_busy),
    .o_done(o_uf_done),
    .o_uflow(o_uf_flag),
    .o_mant(o_uf_mant),
    .o_exp(o_uf_exp)
  );
  // ==========================================
  // Classification.
  logic [95:0] data_q_ff;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data_q_ff <= '0;
    end else begin
      data_q_ff <= i_data;
    end
  end
  fpcls_unpk_s opd;
  logic [14:0] emax;
  logic [15:0] bias;
  logic frac_zero, exp_max, exp_min;
  fpcls_type_e nxt_type;
  logic nxt_snan;
  assign opd = u_bus.opd;
  always_comb begin
    emax = `FPCLS_EXT_EXP_MAX;
    bias = `FPCLS_EXT_BIAS;
    if (opd.fmt == FPCLS_SINGLE) begin
      emax = `FPCLS_SGL_EXP_MAX;
      bias = `FPCLS_SGL_BIAS;
    end else if (opd.fmt == FPCLS_DOUBLE) begin
      emax = `FPCLS_DBL_EXP_MAX;
      bias = `FPCLS_DBL_BIAS;
    end
    exp_max = (opd.exp == emax); // [RL10]
    exp_min = (opd.exp == 15'h0000);
    frac_zero = (opd.mant[62:0] == 63'h0); // [RL24]
    nxt_snan = 1'b0;
    nxt_type = FPCLS_NORM;
    unique case (opd.fmt)
      FPCLS_BYTE, FPCLS_WORD, FPCLS_LONG: nxt_type = FPCLS_INTEGER;
      FPCLS_PACKED: begin
        // Packed decimal never yields a denormal.
        if (data_q_ff[`FPCLS_PKD_EXP_HI:`FPCLS_PKD_EXP_LO] == 12'hfff) begin // [RL12]
          nxt_type = (opd.mant == 64'h0) ? FPCLS_INF : FPCLS_NAN;
          // An infinity has no quiet bit, so only a NaN may report signaling.
          nxt_snan = (opd.mant != 64'h0) && !opd.mant[62]; // [RL23]
        end else if (opd.mant == 64'h0 && data_q_ff[`FPCLS_PKD_DIG16_HI:`FPCLS_PKD_DIG16_LO] == 4'h0) begin
          nxt_type = FPCLS_ZERO; // [RL21]
        end
      end
      default: begin
        if (exp_max) begin
          nxt_type = frac_zero ? FPCLS_INF : FPCLS_NAN; // [RL22]
          nxt_snan = !frac_zero && !opd.mant[62]; // [RL23]
        end else if (exp_min && frac_zero && !(opd.fmt == FPCLS_EXTENDED && opd.mant[63])) begin
          nxt_type = FPCLS_ZERO; // [RL21] [RL24]
        end else if (exp_min && !opd.mant[63]) begin
          nxt_type = FPCLS_DENORM; // [RL13] [RL16]
        end else if (opd.fmt == FPCLS_EXTENDED && !opd.mant[63]) begin
          nxt_type = FPCLS_UNNORM; // [RL19]
        end else begin
          nxt_type = FPCLS_NORM; // [RL8] [RL11] [RL14] [RL15]
        end
      end
    endcase
  end
  // ==========================================
  // Output stage; all outputs registered.
  logic vld_ff, sign_ff, snan_ff, trap_ff;
  fpcls_type_e type_ff;
  logic signed [15:0] exp_ff;
  logic [63:0] mant_ff;
  logic [3:0] ovf_ff;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vld_ff <= 1'b0;
      type_ff <= FPCLS_ZERO;
      sign_ff <= 1'b0;
      snan_ff <= 1'b0;
      trap_ff <= 1'b0;
      exp_ff <= '0;
      mant_ff <= '0;
      ovf_ff <= '0;
    end else begin
      vld_ff <= u_bus.vld;
      type_ff <= nxt_type;
      sign_ff <= opd.sign; // [RL21]
      snan_ff <= nxt_snan;
      trap_ff <= u_bus.vld && (nxt_type == FPCLS_DENORM || nxt_type == FPCLS_UNNORM); // [RL20]
      // Denormals use the minimum exponent plus one as true scale.
      if (opd.fmt == FPCLS_PACKED || opd.fmt inside {FPCLS_BYTE, FPCLS_WORD, FPCLS_LONG}) begin
        exp_ff <= $signed({1'b0, opd.exp});
      end else begin
        exp_ff <= $signed({1'b0, opd.exp}) - $signed(bias) + (exp_min ? 16'sd1 : 16'sd0); // [RL7]
      end
      mant_ff <= opd.mant;
      ovf_ff <= (opd.fmt == FPCLS_PACKED) ? data_q_ff[`FPCLS_PKD_OVF_HI:`FPCLS_PKD_OVF_LO] : 4'h0; // [RL5]
    end
  end
  assign o_vld = vld_ff;
  assign o_type = type_ff;
  assign o_sign = sign_ff;
  assign o_snan = snan_ff;
  assign o_unimp_trap = trap_ff;
  assign o_exp = exp_ff;
  assign o_mant = mant_ff;
  assign o_overflow_exponent_digit = ovf_ff;
endmodule
`default_nettype wire

// file: testbench/fpcls_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker.
module fpcls_top_sva
  import fpcls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_vld,
  input wire fpcls_fmt_e i_fmt,
  input wire logic [95:0] i_data,
  input wire logic i_uf_start,
  input wire logic signed [15:0] i_uf_exp,
  input wire logic o_vld,
  input wire fpcls_type_e o_type,
  input wire logic o_sign,
  input wire logic signed [15:0] o_exp,
  input wire logic [63:0] o_mant,
  input wire logic o_snan,
  input wire logic o_unimp_trap,
  input wire logic o_uf_busy,
  input wire logic o_uf_done,
  input wire logic o_uf_flag,
  input wire logic signed [15:0] o_uf_exp
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic sg = i_vld && i_fmt == FPCLS_SINGLE;
  wire logic [7:0] se = i_data[30:23];
  wire logic fz = i_data[22:0] == 23'h0;
  wire logic ex = i_vld && i_fmt == FPCLS_EXTENDED;
  wire logic [14:0] xe = i_data[94:80];
  wire logic [15:0] ue = {8'h0, se} - 16'h007f;
  vld_delay_a: assert property (i_vld |-> ##2 o_vld) else $error("late");
  sgl_zero_a: assert property (sg && se == 8'h0 && fz |-> ##2 o_type == FPCLS_ZERO && o_sign == $past(i_data[31], 2))
    else $error("zero");
  sgl_denorm_a: assert property (sg && se == 8'h0 && !fz |-> ##2 o_type == FPCLS_DENORM && o_unimp_trap)
    else $error("denorm");
  sgl_inf_a: assert property (sg && se == 8'hff && fz |-> ##2 o_type == FPCLS_INF) else $error("inf");
  sgl_nan_a: assert property (sg && se == 8'hff && !fz |-> ##2 o_snan == !$past(i_data[22], 2))
    else $error("nan");
  sgl_norm_a: assert property (sg && se != 8'h0 && se != 8'hff |-> ##2 o_mant[63] && o_exp == $past(ue, 2))
    else $error("norm");
  ext_unnorm_a: assert property (ex && xe != 15'h0 && xe != 15'h7fff && !i_data[63] |-> ##2 o_type == FPCLS_UNNORM)
    else $error("unnorm");
  ext_minnorm_a: assert property (ex && xe == 15'h0 && i_data[63] |-> ##2 o_type == FPCLS_NORM)
    else $error("min norm");
  trap_cause_a: assert property (o_unimp_trap |-> o_type inside {FPCLS_DENORM, FPCLS_UNNORM})
    else $error("trap");
  uf_flag_a: assert property (i_uf_start && !o_uf_busy && i_uf_exp <= 0 |-> ##[1:70] o_uf_done && o_uf_flag)
    else $error("uflow");
  uf_end_a: assert property (o_uf_done && o_uf_flag |-> o_uf_exp == 16'sh0) else $error("min exp");
endmodule
bind fpcls_top fpcls_top_sva chk (.*);
`default_nettype wire

// file: testbench/fpcls_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Operand source.
module fpcls_core_model
  import fpcls_pkg::*;
(
  input wire logic i_clk,
  output logic o_vld,
  output fpcls_fmt_e o_fmt,
  output logic [95:0] o_data
);
  initial begin
    o_vld = 1'h0;
    o_fmt = FPCLS_SINGLE;
    o_data = 96'h0;
  end
  task automatic put(input fpcls_fmt_e f, input logic [95:0] d);
    o_vld = 1'h1;
    o_fmt = f;
    o_data = d;
    @(posedge i_clk);
    #1;
    o_vld = 1'h0;
    o_data = ~d; // A stale bus must not look like the last operand.
  endtask
endmodule
`default_nettype wire

// file: testbench/fpcls_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench.
module fpcls_top_test;
  import fpcls_pkg::*;
  logic i_clk = 1'h0, i_sys_rst = 1'h1, i_vld, i_uf_start = 1'h0;
  fpcls_fmt_e i_fmt;
  fpcls_type_e o_type;
  logic [95:0] i_data;
  logic signed [15:0] i_uf_exp = 16'h0, o_exp, o_uf_exp;
  logic [63:0] i_uf_mant = 64'h0, o_mant, o_uf_mant;
  logic o_vld, o_sign, o_snan, o_unimp_trap, o_uf_busy, o_uf_done, o_uf_flag;
  logic [3:0] o_overflow_exponent_digit;
  int bad_count = 0, check_count = 0;
  fpcls_core_model core (.i_clk(i_clk), .o_vld(i_vld), .o_fmt(i_fmt), .o_data(i_data));
  fpcls_top dut (.*);
  always #20 i_clk = ~i_clk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic cls(input fpcls_fmt_e f, input logic [95:0] d, input fpcls_type_e t, input logic s, input logic tr);
    core.put(f, d);
    @(posedge i_clk);
    #1;
    chk(o_vld, 1'h1);
    chk(o_type, t);
    chk(o_sign, s);
    chk(o_unimp_trap, tr);
  endtask
  task automatic t_single();
    cls(FPCLS_SINGLE, 96'h80000000, FPCLS_ZERO, 1'h1, 1'h0);
    cls(FPCLS_SINGLE, 96'h1, FPCLS_DENORM, 1'h0, 1'h1);
    chk(o_mant[63], 1'h0);
    cls(FPCLS_SINGLE, 96'h3fc00000, FPCLS_NORM, 1'h0, 1'h0);
    chk(o_mant, 64'hc000000000000000);
    cls(FPCLS_SINGLE, 96'h00800000, FPCLS_NORM, 1'h0, 1'h0);
    chk(o_exp[15:0], 16'hff82);
    cls(FPCLS_SINGLE, 96'hff800000, FPCLS_INF, 1'h1, 1'h0);
    cls(FPCLS_SINGLE, 96'h7f800001, FPCLS_NAN, 1'h0, 1'h0);
    chk(o_snan, 1'h1);
  endtask
  task automatic t_double();
    cls(FPCLS_DOUBLE, 96'h0010000000000000, FPCLS_NORM, 1'h0, 1'h0);
    chk(o_exp[15:0], 16'hfc02);
    cls(FPCLS_DOUBLE, 96'h8000000000000001, FPCLS_DENORM, 1'h1, 1'h1);
    cls(FPCLS_DOUBLE, 96'h7ff0000000000000, FPCLS_INF, 1'h0, 1'h0);
  endtask
  task automatic t_ext();
    cls(FPCLS_EXTENDED, {32'h0, 64'h8000000000000000}, FPCLS_NORM, 1'h0, 1'h0);
    cls(FPCLS_EXTENDED, {32'h3fff0000, 64'h4000000000000000}, FPCLS_UNNORM, 1'h0, 1'h1);
    cls(FPCLS_EXTENDED, {32'h0, 64'h4000000000000000}, FPCLS_DENORM, 1'h0, 1'h1);
    cls(FPCLS_EXTENDED, {32'h80000000, 64'h0}, FPCLS_ZERO, 1'h1, 1'h0);
    cls(FPCLS_EXTENDED, {32'hbfff0000, 64'h8000000000000000}, FPCLS_NORM, 1'h1, 1'h0);
    chk(o_exp[15:0], 16'h0);
  endtask
  task automatic t_packed();
    cls(FPCLS_PACKED, {32'hf1235ff7, 64'h0123456789abcdef}, FPCLS_NORM, 1'h1, 1'h0);
    chk(o_mant, 64'h0123456789abcdef);
    chk(o_overflow_exponent_digit, 4'h5);
    chk(o_exp[15:0], 16'h4123);
    cls(FPCLS_PACKED, {32'h71230007, 64'h1}, FPCLS_NORM, 1'h0, 1'h0);
    chk(o_exp[15:0], 16'h4123);
    cls(FPCLS_PACKED, 96'h0, FPCLS_ZERO, 1'h0, 1'h0);
    cls(FPCLS_PACKED, {32'h7fff0000, 64'h0}, FPCLS_INF, 1'h0, 1'h0);
    chk(o_snan, 1'h0);
    cls(FPCLS_PACKED, {32'hffff0000, 64'h1}, FPCLS_NAN, 1'h1, 1'h0);
    chk(o_snan, 1'h1);
  endtask
  task automatic uf(input logic [15:0] e, input logic [63:0] m, input logic [63:0] wm, input logic fl);
    int n;
    i_uf_start = 1'h1;
    i_uf_exp = e;
    i_uf_mant = m;
    @(posedge i_clk);
    #1;
    i_uf_start = 1'h0;
    i_uf_mant = ~m;
    for (n = 0; n < 100 && o_uf_done !== 1'h1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_uf_done, 1'h1);
    chk(o_uf_busy, 1'h0);
    chk(o_uf_mant, wm);
    chk(o_uf_exp[15:0], fl ? 16'h0 : e);
    chk(o_uf_flag, fl);
  endtask
  task automatic t_uflow();
    uf(16'h0005, 64'h8000000000000000, 64'h8000000000000000, 1'h0);
    uf(16'h0000, 64'h8000000000000001, 64'h8000000000000001, 1'h1);
    uf(16'hfffd, 64'h8000000000000000, 64'h1000000000000000, 1'h1);
    uf(16'hff9c, 64'h8000000000000000, 64'h0, 1'h1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 1'h0;
    t_single();
    t_double();
    t_ext();
    t_packed();
    t_uflow();
    finish_test();
  end
endmodule
`default_nettype wire
